/* File: dv/mcc_osc_model.sv */
// Far-side oscillators: tick pulses and analog ready for each source.
// Assumes index 0 fast, 1 slow, 2 crystal, 3 pin, all on aclk.
`timescale 1ns/1ps
`default_nettype none
module mcc_osc_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] osc_power_on,
  output logic [3:0] osc_tick,
  output logic [3:0] osc_analog_ready
);
  // Unequal periods so a wrong source shows in the tick pattern
  localparam logic [3:0][2:0] PER = {3'h3, 3'h7, 3'h5, 3'h2};
  logic [2:0] ph_q [4];
  logic [2:0] up_q [4];
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      // Unpowered ones stand still; the pin clock runs regardless
      if (!aresetn || !(osc_power_on[i] || i == 3)) begin
        ph_q[i] <= 3'h0;
        up_q[i] <= 3'h0;
      end else begin
        ph_q[i] <= (ph_q[i] == PER[i] - 3'h1) ? 3'h0 : ph_q[i] + 3'h1;
        up_q[i] <= (up_q[i] == 3'h6) ? up_q[i] : up_q[i] + 3'h1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      osc_tick[i] = (up_q[i] != 3'h0) && (ph_q[i] == 3'h0);
      osc_analog_ready[i] = (up_q[i] == 3'h6);
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench: AXI4-Lite register access and clock outputs.
// Assumes the oscillator stand-in drives ticks on the far side.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] e;
    logic [1:0] r;
  } mcc_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, sleep_active = 1'b0, periph_uses_sysclk = 1'b0;
  logic calibration_lock_fuse = 1'b0, frequency_select_fuse = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf, periph_clk_req = 4'h0, osc_tick, osc_analog_ready, osc_power_on;
  logic [3:0] osc_gate_open, temp_out;
  logic [5:0] fine_out;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, main_clock, peripheral_clock;
  logic system_clock_to_pin, ext_in;
  int err_total = 0, comparisons = 0, cyc = 0;
  // Reserved divider codes divide by two
  logic [6:0] ratio_tab [16] = '{7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h02, 7'h02,
    7'h06, 7'h0a, 7'h0c, 7'h18, 7'h30, 7'h02, 7'h02, 7'h02};
  logic [15:0] rst_rows [9] = '{16'h0000, 16'h0411, 16'h0800, 16'h4000, 16'h4415,
    16'h4803, 16'h6000, 16'h7000, 16'h0c10};
  mcc_row_t rows [12] = '{{8'h00, 8'h80, 8'h80, 2'h0}, {8'h40, 8'h02, 8'h02, 2'h0},
    {8'h44, 8'hff, 8'h3f, 2'h0}, {8'h48, 8'hff, 8'h0f, 2'h0}, {8'h60, 8'h02, 8'h02, 2'h0},
    {8'h70, 8'h34, 8'h34, 2'h0}, {8'h70, 8'h35, 8'h35, 2'h0}, {8'h70, 8'h05, 8'h35, 2'h0},
    {8'h70, 8'h00, 8'h34, 2'h0}, {8'h14, 8'h55, 8'h00, 2'h2}, {8'h01, 8'h55, 8'h00, 2'h2},
    {8'h08, 8'h00, 8'h00, 2'h0}};
  mcc_top #(.XOSC_WAIT_1K(32'h4), .FINE_FACTORY_16(6'h15), .FINE_FACTORY_20(6'h2a),
    .TEMP_FACTORY_16(4'h3), .TEMP_FACTORY_20(4'h5)) dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .osc_tick, .osc_analog_ready, .periph_clk_req, .sleep_active, .periph_uses_sysclk,
    .calibration_lock_fuse, .frequency_select_fuse, .main_clock, .peripheral_clock,
    .system_clock_to_pin, .osc_power_on, .osc_gate_open, .fast_osc_fine_trim_field(fine_out),
    .fast_osc_temp_slope_field(temp_out), .crystal_ext_input(ext_in));
  mcc_osc_model osc (.aclk, .aresetn, .osc_power_on, .osc_tick, .osc_analog_ready);
  always #20 aclk = ~aclk;
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Ceiling well above the slowest divider sweep
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 32'h9c40) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    // Response ready stays high; each call drives it high again before waiting
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task automatic wok(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", {30'h0, r}, 32'h0);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk($sformatf("reg %h", a), d, {24'h0, e});
    chk("rresp", {30'h0, r}, 32'h0);
  endtask
  // Main ticks between two peripheral ticks, after one to resync
  task automatic ratio_of(output int m);
    do @(posedge aclk); while (!peripheral_clock);
    m = 0;
    do begin
      @(posedge aclk);
      m += main_clock;
    end while (!peripheral_clock);
  endtask
  // Counts main and pin pulses; bad counts main pulses not led by a source tick
  task automatic watch(input int n, input int s, output int mc, output int pn, output int bad);
    logic t;
    t = 1'b1;
    mc = 0;
    pn = 0;
    bad = 0;
    repeat (n) begin
      @(posedge aclk);
      if (main_clock && !t) bad++;
      mc += main_clock;
      pn += system_clock_to_pin;
      t = osc_tick[s];
    end
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int m, mc, pn, bad;
    do_reset();
    foreach (rst_rows[i]) rchk(rst_rows[i][15:8], rst_rows[i][7:0]);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w, r);
      chk("bresp", {30'h0, r}, {30'h0, rows[i].r});
      rd(rows[i].a, d, r);
      chk("rdata", d, {24'h0, rows[i].e});
      chk("rresp", {30'h0, r}, {30'h0, rows[i].r});
    end
    chk("fine out", {26'h0, fine_out}, 32'h3f);
    chk("temp out", {28'h0, temp_out}, 32'hf);
    chk("ext in", {31'h0, ext_in}, 32'h1);
    wstrb <= 4'h0;
    wok(8'h60, 8'h00);
    wstrb <= 4'hf;
    rchk(8'h60, 8'h02);
    rchk(8'h0c, 8'h10);
    // Fast source: each of the 16 divider codes, then prescaler off, gives the expected ratio
    for (int c = 0; c < 17; c++) begin
      wok(8'h04, (c < 16) ? {3'h0, c[3:0], 1'b1} : 8'h18);
      ratio_of(m);
      chk("ratio", m, (c < 16) ? {25'h0, ratio_tab[c]} : 32'h1);
    end
    watch(40, 0, mc, pn, bad);
    chk("pin", pn, mc);
    chk("fast src", bad, 32'h0);
    sleep_active <= 1'b1;
    repeat (2) @(posedge aclk);
    watch(40, 0, mc, pn, bad);
    chk("pin sleep", pn, 32'h0);
    periph_uses_sysclk <= 1'b1;
    repeat (2) @(posedge aclk);
    watch(40, 0, mc, pn, bad);
    chk("pin used", pn, mc);
    chk("gate idle", {31'h0, osc_gate_open[0]}, 32'h0);
    periph_clk_req <= 4'h1;
    repeat (12) @(posedge aclk);
    chk("gate req", {31'h0, osc_gate_open[0]}, 32'h1);
    periph_clk_req <= 4'h0;
    sleep_active <= 1'b0;
    wok(8'h00, 8'h01);
    rchk(8'h0c, 8'h11);
    repeat (60) @(posedge aclk);
    rchk(8'h0c, 8'h20);
    watch(60, 1, mc, pn, bad);
    chk("slow src", bad, 32'h0);
    chk("slow run", {31'h0, mc != 0}, 32'h1);
    chk("pin off", pn, 32'h0);
    chk("power", {28'h0, osc_power_on}, 32'h3);
    wok(8'h08, 8'h01);
    wok(8'h08, 8'h00);
    wok(8'h00, 8'h83);
    wok(8'h04, 8'h01);
    rchk(8'h00, 8'h01);
    rchk(8'h04, 8'h18);
    rchk(8'h08, 8'h00);
    wok(8'h44, 8'h07);
    rchk(8'h44, 8'h07);
    calibration_lock_fuse <= 1'b1;
    frequency_select_fuse <= 1'b1;
    do_reset();
    wok(8'h44, 8'h01);
    wok(8'h00, 8'h80);
    rchk(8'h44, 8'h2a);
    rchk(8'h48, 8'h85);
    rchk(8'h00, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: rtl/mcc_pkg.sv */
// Constants, field layout and state type for the main clock controller.
// Assumes 8-bit registers, one per aligned 32-bit AXI4-Lite word.
package mcc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_MAIN_CTRL = 5'h00;
  localparam logic [4:0] IDX_PRESCALE = 5'h01;
  localparam logic [4:0] IDX_LOCK = 5'h02;
  localparam logic [4:0] IDX_STATE = 5'h03;
  localparam logic [4:0] IDX_FAST_CTRL = 5'h10;
  localparam logic [4:0] IDX_FINE_TRIM = 5'h11;
  localparam logic [4:0] IDX_TEMP_TRIM = 5'h12;
  localparam logic [4:0] IDX_SLOW_CTRL = 5'h18;
  localparam logic [4:0] IDX_XOSC_CTRL = 5'h1c;

  // Field positions
  localparam int unsigned SRC_SEL_LSB = 0;
  localparam int unsigned SYSTEM_CLOCK_TO_PIN_BIT = 7;
  localparam int unsigned PEN_BIT = 0;
  localparam int unsigned PRESCALE_DIVIDER_LSB = 1;
  localparam int unsigned MAIN_SETTINGS_LOCK_BIT = 0;
  localparam int unsigned ST_PENDING_BIT = 0;
  localparam int unsigned ST_FAST_BIT = 4;
  localparam int unsigned ST_SLOW_BIT = 5;
  localparam int unsigned ST_XOSC_BIT = 6;
  localparam int unsigned ST_EXT_BIT = 7;
  localparam int unsigned KEEP_BIT = 1;
  localparam int unsigned FINE_LSB = 0;
  localparam int unsigned TEMP_LSB = 0;
  localparam int unsigned CAL_LOCK_BIT = 7;
  localparam int unsigned XOSC_EN_BIT = 0;
  localparam int unsigned XOSC_SEL_BIT = 2;
  localparam int unsigned CRYSTAL_STARTUP_WAIT_LSB = 4;

  // Reset values
  localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
  localparam logic [7:0] PRESCALE_RST = 8'h11;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Source codes
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_XOSC = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // Start-up counts in oscillator cycles
  localparam logic [16:0] FAST_GATE_CYC = 17'h00004;
  localparam logic [16:0] SLOW_GATE_CYC = 17'h00004;
  localparam logic [16:0] EXT_START_CYC = 17'h00002;
  localparam logic [16:0] XOSC_EXT_IN_CYC = 17'h00002;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MCC_STEADY = 2'b01,
    MCC_SWITCH = 2'b10
  } mcc_sw_t;

  // Division ratio of a divider code; reserved codes divide by two
  function automatic logic [6:0] mcc_ratio(input logic [3:0] code);
    case (code)
      4'h0: mcc_ratio = 7'h02;
      4'h1: mcc_ratio = 7'h04;
      4'h2: mcc_ratio = 7'h08;
      4'h3: mcc_ratio = 7'h10;
      4'h4: mcc_ratio = 7'h20;
      4'h5: mcc_ratio = 7'h40;
      4'h8: mcc_ratio = 7'h06;
      4'h9: mcc_ratio = 7'h0a;
      4'ha: mcc_ratio = 7'h0c;
      4'hb: mcc_ratio = 7'h18;
      4'hc: mcc_ratio = 7'h30;
      default: mcc_ratio = 7'h02;
    endcase
  endfunction

endpackage

/* File: rtl/mcc_top.sv */
// Main clock controller: source select, prescaler, clock pin, lock,
// oscillator start-up tracking and trim registers behind AXI4-Lite.
// Assumes oscillator edges arrive as one-cycle pulses synchronous to aclk.
//
// Behaviour
// - Two-bit field picks fast, slow, crystal or external pin as main clock.
// - Clock-out bit drives the system clock onto the clock output pin.
// - In sleep the pin is quiet unless a peripheral uses the system clock.
// - Enabled prescaler divides by 2..64 or 6..48 per the four-bit code.
// - Prescaler disabled passes the main clock straight to peripherals.
// - Divider code may change at any time and takes effect directly.
// - Lock bit freezes both main control registers and active source trim.
// - Once set the lock register is inaccessible until hardware reset.
// - Lock bit loads from the calibration lock fuse at reset.
// - Status shows external started and crystal, slow, fast stable.
// - Stable flag reads one only while the source is requested.
// - Pending bit shows a source switch; it ends when new source is stable.
// - Fast keep-running bit holds that oscillator on in every mode.
// - Fast oscillator output reaches no consumer unless requested.
// - Gate opens after four cycles; keep-running skips analog start-up.
// - Six-bit fine trim loads factory value chosen by frequency fuse.
// - Calibration lock flag, from fuse, blocks both trim registers.
// - Crystal start-up waits 1k/16k/32k/64k cycles, two for external input.
// - Crystal select and start-up fields ignore writes while on or stable.
`timescale 1ns/1ps
`default_nettype none

module mcc_top #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned XOSC_WAIT_1K = 1024,
  parameter int unsigned XOSC_WAIT_16K = 16384,
  parameter int unsigned XOSC_WAIT_32K = 32768,
  parameter int unsigned XOSC_WAIT_64K = 65536,
  parameter logic [5:0] FINE_FACTORY_16 = 6'h20,
  parameter logic [5:0] FINE_FACTORY_20 = 6'h20,
  parameter logic [3:0] TEMP_FACTORY_16 = 4'h8,
  parameter logic [3:0] TEMP_FACTORY_20 = 4'h8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [3:0] osc_tick,
  input wire logic [3:0] osc_analog_ready,
  input wire logic [3:0] periph_clk_req,
  input wire logic sleep_active,
  input wire logic periph_uses_sysclk,
  input wire logic calibration_lock_fuse,
  input wire logic frequency_select_fuse,
  output logic main_clock,
  output logic peripheral_clock,
  output logic system_clock_to_pin,
  output logic [3:0] osc_power_on,
  output logic [3:0] osc_gate_open,
  output logic [5:0] fast_osc_fine_trim_field,
  output logic [3:0] fast_osc_temp_slope_field,
  output logic crystal_ext_input
);

  // Control registers
  logic system_clock_to_pin_q;
  logic [1:0] main_source_select_q;
  logic [3:0] prescale_divider_q;
  logic prescale_on_q;
  logic main_settings_lock_q;
  logic cal_lock_q;
  logic fast_keep_q;
  logic slow_keep_q;
  logic [5:0] fine_q;
  logic [3:0] temp_q;
  logic xosc_en_q;
  logic xosc_keep_q;
  logic xosc_sel_q;
  logic [1:0] crystal_startup_wait_q;
  logic [1:0] active_q;
  mcc_pkg::mcc_sw_t sw_q;
  mcc_pkg::mcc_sw_t sw_d;
  logic [6:0] pcnt_q;
  logic main_q;
  logic per_q;
  logic pin_q;

  // Bus state
  logic aw_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_full_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [7:0] rdata_q;
  logic [1:0] rresp_q;

  // Source tracking
  logic [16:0] cnt_q [4];
  logic [16:0] need [4];
  logic [3:0] req;
  logic [3:0] run;
  logic [3:0] keep;
  logic [3:0] analog_ok;
  logic [3:0] done;
  logic [3:0] stab;

  // Write channel decode
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire [ADDR_W-1:0] wr_addr = aw_full_q ? aw_addr_q : awaddr;
  wire [7:0] wr_data = w_full_q ? w_data_q : wdata[7:0];
  wire wr_strb = w_full_q ? w_strb_q : wstrb[0];
  wire wr_go = (aw_full_q || aw_take) && (w_full_q || w_take);
  wire [4:0] wr_idx = wr_addr[6:2];
  wire [4:0] rd_idx = araddr[6:2];

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [4:0] idx;
    idx = a[6:2];
    mapped = (a[1:0] == 2'h0) && (a[ADDR_W-1:7] == '0) &&
      (idx == mcc_pkg::IDX_MAIN_CTRL || idx == mcc_pkg::IDX_PRESCALE ||
       idx == mcc_pkg::IDX_LOCK || idx == mcc_pkg::IDX_STATE ||
       idx == mcc_pkg::IDX_FAST_CTRL || idx == mcc_pkg::IDX_FINE_TRIM ||
       idx == mcc_pkg::IDX_TEMP_TRIM || idx == mcc_pkg::IDX_SLOW_CTRL ||
       idx == mcc_pkg::IDX_XOSC_CTRL);
  endfunction

  wire wr_ok = mapped(wr_addr);
  wire we = wr_go && wr_ok && wr_strb;
  wire we_main = we && wr_idx == mcc_pkg::IDX_MAIN_CTRL && !main_settings_lock_q;
  wire we_pre = we && wr_idx == mcc_pkg::IDX_PRESCALE && !main_settings_lock_q;
  wire we_lock = we && wr_idx == mcc_pkg::IDX_LOCK && !main_settings_lock_q;
  // Trim freezes under calibration lock, or main lock while fast is main
  wire trim_frozen = cal_lock_q || (main_settings_lock_q && active_q == mcc_pkg::SRC_FAST);
  wire we_fine = we && wr_idx == mcc_pkg::IDX_FINE_TRIM && !trim_frozen;
  wire we_temp = we && wr_idx == mcc_pkg::IDX_TEMP_TRIM && !trim_frozen;
  wire we_xosc = we && wr_idx == mcc_pkg::IDX_XOSC_CTRL;
  wire xosc_cfg_open = !xosc_en_q && !stab[mcc_pkg::SRC_XOSC];

  // Status and readback
  wire pending = (sw_q == mcc_pkg::MCC_SWITCH);
  wire [7:0] state_byte = {stab[mcc_pkg::SRC_EXT], stab[mcc_pkg::SRC_XOSC],
    stab[mcc_pkg::SRC_SLOW], stab[mcc_pkg::SRC_FAST], 3'h0, pending};
  wire [7:0] rd_byte =
    (rd_idx == mcc_pkg::IDX_MAIN_CTRL) ? {system_clock_to_pin_q, 5'h00, main_source_select_q} :
    (rd_idx == mcc_pkg::IDX_PRESCALE) ? {3'h0, prescale_divider_q, prescale_on_q} :
    (rd_idx == mcc_pkg::IDX_LOCK) ? 8'h00 :
    (rd_idx == mcc_pkg::IDX_STATE) ? state_byte :
    (rd_idx == mcc_pkg::IDX_FAST_CTRL) ? {6'h00, fast_keep_q, 1'b0} :
    (rd_idx == mcc_pkg::IDX_FINE_TRIM) ? {2'h0, fine_q} :
    (rd_idx == mcc_pkg::IDX_TEMP_TRIM) ? {cal_lock_q, 3'h0, temp_q} :
    (rd_idx == mcc_pkg::IDX_SLOW_CTRL) ? {6'h00, slow_keep_q, 1'b0} :
    {2'h0, crystal_startup_wait_q, 1'b0, xosc_sel_q, xosc_keep_q, xosc_en_q};

  assign awready = !aw_full_q && !bvalid_q;
  assign wready = !w_full_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = {24'h000000, rdata_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= mcc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? mcc_pkg::RESP_OKAY : mcc_pkg::RESP_SLVERR;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= wdata[7:0];
        w_strb_q <= wstrb[0];
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= mcc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= mapped(araddr) ? rd_byte : 8'h00;
      rresp_q <= mapped(araddr) ? mcc_pkg::RESP_OKAY : mcc_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Register file; fuse levels are sampled while reset is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_clock_to_pin_q <= mcc_pkg::MAIN_CTRL_RST[mcc_pkg::SYSTEM_CLOCK_TO_PIN_BIT];
      main_source_select_q <= mcc_pkg::MAIN_CTRL_RST[mcc_pkg::SRC_SEL_LSB +: 2];
      prescale_on_q <= mcc_pkg::PRESCALE_RST[mcc_pkg::PEN_BIT];
      prescale_divider_q <= mcc_pkg::PRESCALE_RST[mcc_pkg::PRESCALE_DIVIDER_LSB +: 4];
      main_settings_lock_q <= calibration_lock_fuse;
      cal_lock_q <= calibration_lock_fuse;
      fine_q <= frequency_select_fuse ? FINE_FACTORY_20 : FINE_FACTORY_16;
      temp_q <= frequency_select_fuse ? TEMP_FACTORY_20 : TEMP_FACTORY_16;
      fast_keep_q <= mcc_pkg::CTRL_RST[mcc_pkg::KEEP_BIT];
      slow_keep_q <= mcc_pkg::CTRL_RST[mcc_pkg::KEEP_BIT];
      xosc_en_q <= mcc_pkg::CTRL_RST[mcc_pkg::XOSC_EN_BIT];
      xosc_keep_q <= mcc_pkg::CTRL_RST[mcc_pkg::KEEP_BIT];
      xosc_sel_q <= mcc_pkg::CTRL_RST[mcc_pkg::XOSC_SEL_BIT];
      crystal_startup_wait_q <= mcc_pkg::CTRL_RST[mcc_pkg::CRYSTAL_STARTUP_WAIT_LSB +: 2];
    end else begin
      if (we_main) begin
        system_clock_to_pin_q <= wr_data[mcc_pkg::SYSTEM_CLOCK_TO_PIN_BIT];
        main_source_select_q <= wr_data[mcc_pkg::SRC_SEL_LSB +: 2];
      end
      if (we_pre) begin
        prescale_on_q <= wr_data[mcc_pkg::PEN_BIT];
        prescale_divider_q <= wr_data[mcc_pkg::PRESCALE_DIVIDER_LSB +: 4];
      end
      // Sticky: only a hardware reset clears it
      if (we_lock && wr_data[mcc_pkg::MAIN_SETTINGS_LOCK_BIT]) begin
        main_settings_lock_q <= 1'b1;
      end
      if (we_fine) begin
        fine_q <= wr_data[mcc_pkg::FINE_LSB +: 6];
      end
      if (we_temp) begin
        temp_q <= wr_data[mcc_pkg::TEMP_LSB +: 4];
      end
      if (we && wr_idx == mcc_pkg::IDX_FAST_CTRL) begin
        fast_keep_q <= wr_data[mcc_pkg::KEEP_BIT];
      end
      if (we && wr_idx == mcc_pkg::IDX_SLOW_CTRL) begin
        slow_keep_q <= wr_data[mcc_pkg::KEEP_BIT];
      end
      if (we_xosc) begin
        xosc_en_q <= wr_data[mcc_pkg::XOSC_EN_BIT];
        xosc_keep_q <= wr_data[mcc_pkg::KEEP_BIT];
      end
      if (we_xosc && xosc_cfg_open) begin
        xosc_sel_q <= wr_data[mcc_pkg::XOSC_SEL_BIT];
        crystal_startup_wait_q <= wr_data[mcc_pkg::CRYSTAL_STARTUP_WAIT_LSB +: 2];
      end
    end
  end

  // Per-source requests, power and start-up counting
  assign keep = {1'b0, xosc_keep_q, slow_keep_q, fast_keep_q};
  assign need[mcc_pkg::SRC_FAST] = mcc_pkg::FAST_GATE_CYC;
  assign need[mcc_pkg::SRC_SLOW] = mcc_pkg::SLOW_GATE_CYC;
  assign need[mcc_pkg::SRC_EXT] = mcc_pkg::EXT_START_CYC;
  assign need[mcc_pkg::SRC_XOSC] = xosc_sel_q ? mcc_pkg::XOSC_EXT_IN_CYC :
    (crystal_startup_wait_q == 2'h0) ? 17'(XOSC_WAIT_1K) :
    (crystal_startup_wait_q == 2'h1) ? 17'(XOSC_WAIT_16K) :
    (crystal_startup_wait_q == 2'h2) ? 17'(XOSC_WAIT_32K) : 17'(XOSC_WAIT_64K);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_src
      assign req[gi] = periph_clk_req[gi] || main_source_select_q == 2'(gi) ||
        active_q == 2'(gi);
      // Keep-running powers an oscillator even with no request; the crystal also needs its enable
      assign run[gi] = (gi == 2) ? xosc_en_q && (req[gi] || keep[gi]) :
        req[gi] || keep[gi];
      // A kept oscillator skips the analog wait, not the gate count
      assign analog_ok[gi] = osc_analog_ready[gi] || keep[gi];
      assign done[gi] = cnt_q[gi] >= need[gi];
      assign stab[gi] = req[gi] && run[gi] && done[gi];
      assign osc_gate_open[gi] = stab[gi] && periph_clk_req[gi];
      assign osc_power_on[gi] = run[gi];
      always_ff @(posedge aclk) begin
        if (!aresetn || !run[gi] || !req[gi]) begin
          cnt_q[gi] <= '0;
        end else if (analog_ok[gi] && osc_tick[gi] && !done[gi]) begin
          cnt_q[gi] <= cnt_q[gi] + 17'h00001;
        end
      end
    end
  endgenerate

  // Source switch: old source keeps ticking until the new one is stable
  wire new_ready = stab[main_source_select_q];
  always_comb begin
    sw_d = sw_q;
    case (sw_q)
      mcc_pkg::MCC_STEADY: begin
        if (main_source_select_q != active_q) begin
          sw_d = mcc_pkg::MCC_SWITCH;
        end
      end
      mcc_pkg::MCC_SWITCH: begin
        if (new_ready || main_source_select_q == active_q) begin
          sw_d = mcc_pkg::MCC_STEADY;
        end
      end
      default: sw_d = mcc_pkg::MCC_STEADY;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_q <= mcc_pkg::MCC_STEADY;
      active_q <= mcc_pkg::SRC_FAST;
    end else begin
      sw_q <= sw_d;
      // Whole pulses only, so no runt edge at the changeover
      if (sw_q == mcc_pkg::MCC_SWITCH && new_ready) begin
        active_q <= main_source_select_q;
      end
    end
  end

  // Main tick, prescaler and clock pin
  wire main_tick = osc_tick[active_q] && done[active_q];
  wire [6:0] ratio = mcc_pkg::mcc_ratio(prescale_divider_q);
  // Counter past a shortened ratio wraps at once instead of running on
  wire pwrap = pcnt_q >= ratio - 7'h01;
  wire pin_open = system_clock_to_pin_q && (!sleep_active || periph_uses_sysclk);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcnt_q <= 7'h00;
      main_q <= 1'b0;
      per_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      main_q <= main_tick;
      pin_q <= main_tick && pin_open;
      per_q <= main_tick && (!prescale_on_q || pwrap);
      if (main_tick) begin
        pcnt_q <= (!prescale_on_q || pwrap) ? 7'h00 : pcnt_q + 7'h01;
      end
    end
  end

  assign main_clock = main_q;
  assign peripheral_clock = per_q;
  assign system_clock_to_pin = pin_q;
  assign fast_osc_fine_trim_field = fine_q;
  assign fast_osc_temp_slope_field = temp_q;
  assign crystal_ext_input = xosc_sel_q;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pin_cause: assert property (pin_q |-> $past(system_clock_to_pin_q && main_tick))
    else $error("clock pin active without clock-out and main tick");
  a_sleep_quiet: assert property ($past(sleep_active && !periph_uses_sysclk) |-> !pin_q)
    else $error("clock pin toggled during sleep");
  a_prescale_off: assert property ($past(main_tick && !prescale_on_q) |-> per_q)
    else $error("undivided peripheral tick missing");
  a_div_min: assert property (per_q && $past(prescale_on_q) && $past(pcnt_q) == 7'h00 |->
    $past(ratio) <= 7'h01 || !$past(prescale_on_q))
    else $error("peripheral tick before divider count elapsed");
  a_lock_sticky: assert property (main_settings_lock_q |=> main_settings_lock_q)
    else $error("lock cleared without reset");
  a_lock_freeze: assert property (main_settings_lock_q |=>
    $stable(main_source_select_q) && $stable(prescale_divider_q) && $stable(system_clock_to_pin_q))
    else $error("locked main control changed");
  a_pending_flag: assert property (main_source_select_q != active_q |=> pending or
    (main_source_select_q == active_q))
    else $error("switch pending not shown");
  a_switch_done: assert property (pending && new_ready |=>
    active_q == $past(main_source_select_q) ##1 !pending)
    else $error("switch not completed when source stable");
  a_stable_req: assert property (|(stab & ~req) == 1'b0)
    else $error("stable flag set on unrequested source");
  a_gate_req: assert property (|(osc_gate_open & ~periph_clk_req) == 1'b0)
    else $error("oscillator output without request");
  a_trim_lock: assert property (cal_lock_q |=> $stable(fine_q) && $stable(temp_q))
    else $error("trim changed under calibration lock");
  a_xosc_cfg: assert property (xosc_en_q |=> $stable(xosc_sel_q) && $stable(crystal_startup_wait_q))
    else $error("crystal config changed while enabled");

  c_switch: cover property (pending ##[1:50] !pending);
  c_lock_set: cover property (!main_settings_lock_q ##1 main_settings_lock_q);
  c_divided: cover property (prescale_on_q && per_q);
  c_pin: cover property (pin_q);

endmodule

`default_nettype wire
